/* hw/upllc_pkg.sv */
/*
 * Package for the USB PLL divider control block: register offsets,
 * field positions, reset values and feed sequence codes.
 * Assumes a 32-bit register port with word-aligned byte offsets.
 */
package upllc_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_USB_CONTROL = 8'h0c;
    localparam logic [7:0] OFS_FB_CODE = 8'h10;
    localparam logic [7:0] OFS_PRE_POST_CODE = 8'h14;
    localparam logic [7:0] OFS_CL_FIRST = 8'h18;
    localparam logic [7:0] OFS_CL_SECOND = 8'h1c;
    localparam logic [7:0] OFS_CL_GLOBAL = 8'h20;
    localparam logic [7:0] OFS_CLK_DETECT = 8'h24;
    localparam logic [7:0] OFS_CLK_PRESENCE = 8'h2c;
    localparam logic [7:0] OFS_USB_FEED = 8'h30;
    localparam logic [7:0] OFS_CL_FEED = 8'h34;

    // Control register bit positions
    localparam int BIT_POWER_DOWN = 0;
    localparam int BIT_CLK_EN = 1;
    localparam int BIT_PLL_BYPASS = 2;
    localparam int BIT_PRE_BYPASS = 3;
    localparam int BIT_POST_BYPASS = 4;
    localparam int BIT_SKEW = 5;
    localparam int BIT_FREE_RUN = 6;
    localparam int BIT_FB_REQ = 7;
    localparam int BIT_PRE_REQ = 8;
    localparam int BIT_POST_REQ = 9;
    localparam int BIT_SRC_SEL = 24;

    // Field widths and post code LSB position
    localparam int FB_W = 17;
    localparam int PRE_W = 10;
    localparam int POST_W = 6;
    localparam int POST_LSB = 10;

    // Reset values and writable masks
    localparam logic [31:0] RST_USB_CONTROL = 32'h00f9_0001;
    localparam logic [31:0] MASK_USB_CONTROL = 32'h7fff_ffff;
    localparam logic [31:0] RST_CL_FIRST = 32'h02e3_b190;
    localparam logic [31:0] RST_CL_SECOND = 32'h02e1_21e0;
    localparam logic [31:0] RST_CL_GLOBAL = 32'h0000_00c0;
    localparam logic [31:0] RST_CLK_DETECT = 32'h0000_11ad;
    localparam logic [31:0] RST_CLK_PRESENCE = 32'h0000_000f;
    localparam logic [31:0] MASK_CL_CTRL = 32'h0fff_ffff;
    localparam logic [31:0] MASK_CL_GLOBAL = 32'h0000_7fff;
    localparam logic [31:0] MASK_LOW16 = 32'h0000_ffff;

    // Soft decoder presets, chosen by control bit 30
    localparam int BIT_SOFT_SEL = 30;
    localparam logic [16:0] SOFT_M0 = 17'h00258;
    localparam logic [9:0] SOFT_N0 = 10'h071;
    localparam logic [5:0] SOFT_P0 = 6'h03;
    localparam logic [16:0] SOFT_M1 = 17'h0005c;
    localparam logic [9:0] SOFT_N1 = 10'h00d;
    localparam logic [5:0] SOFT_P1 = 6'h04;

    // Feed sequence: two words written back to back to a feed register
    localparam logic [7:0] FEED_KEY1 = 8'haa;
    localparam logic [7:0] FEED_KEY2 = 8'h55;

    // Feed detector states
    typedef enum logic [1:0] {
        UPLLC_FEED_IDLE = 2'b01,
        UPLLC_FEED_ARMED = 2'b10
    } upllc_feed_state_t;

endpackage : upllc_pkg

/* hw/upllc_feed_if.sv */
/*
 * Interface carrying write strobes into a feed detector and its accept
 * pulse back. Assumes both ends share mclk.
 */
`timescale 1ns/100ps
interface upllc_feed_if;
    logic wr;
    logic hit;
    logic [7:0] data;
    logic accept;
    modport det (input wr, input hit, input data, output accept);
    modport ctl (output wr, output hit, output data, input accept);
endinterface : upllc_feed_if

/* hw/upllc_feed_det.sv */
/*
 * Feed sequence detector: key1 then key2 written to the feed register
 * as consecutive bus writes gives a one-cycle accept pulse.
 * Assumes synchronous strobes on mclk; any other write disarms.
 */
`timescale 1ns/100ps
module upllc_feed_det (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Feed port
    upllc_feed_if.det feed
);
    typedef struct packed {
        upllc_pkg::upllc_feed_state_t state;
        logic accept;
    } upllc_fd_t;

    upllc_fd_t cur_ff;
    upllc_fd_t nxt_cur;

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.accept = 1'b0;
        if (feed.wr) begin
            case (cur_ff.state)
                upllc_pkg::UPLLC_FEED_IDLE: begin
                    if (feed.hit && feed.data == upllc_pkg::FEED_KEY1) begin
                        nxt_cur.state = upllc_pkg::UPLLC_FEED_ARMED;
                    end
                end
                default: begin
                    nxt_cur.state = upllc_pkg::UPLLC_FEED_IDLE;
                    if (feed.hit && feed.data == upllc_pkg::FEED_KEY2) begin
                        nxt_cur.accept = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cur_ff <= '{state: upllc_pkg::UPLLC_FEED_IDLE, accept: 1'b0};
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign feed.accept = cur_ff.accept;

endmodule : upllc_feed_det

/* hw/upllc_top.sv */
/*
 * USB PLL divider control: control register, raw divider codes, shadow
 * dividers loaded by a feed sequence, contactless PLL register map.
 * Assumes a single-cycle register port on mclk; analog PLL is outside.
 */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps

// Summary of operation
// - Post-divider change request bit 9 loads register-held post code
// - Pre-divider change request bit 8 loads register-held pre code
// - Feedback change request bit 7 loads register-held feedback code
// - Bit 6 selects free running mode, reset zero
// - Bit 5 enables skew mode, reset zero
// - Bit 4 bypasses the post-divider
// - Bit 3 bypasses the pre-divider
// - Bit 2 bypasses the whole PLL, output equals input
// - Bit 1 gates the PLL output clock, reset zero
// - Bit 0 powers the PLL down, resets to one
// - Feedback raw code in bits 16:0, reset zero
// - Post code bits 15:10, pre code bits 9:0, reset zero
// - New USB divider codes wait for a correct USB feed sequence
// - First contactless control register waits for its feed sequence
// - Contactless unused bits ignore writes and read zero
// - Bit 24 picks register codes when one, soft decoder when zero
module upllc_top (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // USB PLL controls
    output logic pll_power_down,
    output logic pll_out_clock_enable,
    output logic pll_bypass,
    output logic pre_div_bypass,
    output logic post_div_bypass,
    output logic skew_enable,
    output logic free_run_enable,
    // Active USB PLL dividers
    output logic [16:0] fb_div_ratio,
    output logic [9:0] pre_div_ratio,
    output logic [5:0] post_div_ratio,
    // Active contactless PLL settings
    output logic [31:0] cl_first_active,
    output logic [31:0] cl_second_active,
    output logic [31:0] cl_global_cfg
);
    typedef struct packed {
        logic [31:0] usb_ctrl;
        logic [31:0] fb_code;
        logic [31:0] pre_post_code;
        logic [31:0] cl_first;
        logic [31:0] cl_first_act;
        logic [31:0] cl_second;
        logic [31:0] cl_second_act;
        logic [31:0] cl_global;
        logic [31:0] clk_detect;
        logic [31:0] clk_presence;
        logic [16:0] fb_act;
        logic [9:0] pre_act;
        logic [5:0] post_act;
        logic [31:0] rdata;
    } upllc_regs_t;

    upllc_regs_t cur_ff;
    upllc_regs_t nxt_cur;

    upllc_feed_if usb_feed ();
    upllc_feed_if cl_feed ();

    assign usb_feed.wr = reg_wr;
    assign usb_feed.hit = reg_addr == upllc_pkg::OFS_USB_FEED;
    assign usb_feed.data = reg_wdata[7:0];
    assign cl_feed.wr = reg_wr;
    assign cl_feed.hit = reg_addr == upllc_pkg::OFS_CL_FEED;
    assign cl_feed.data = reg_wdata[7:0];

    upllc_feed_det u_usb_feed (
        .mclk(mclk),
        .resetn(resetn),
        .feed(usb_feed)
    );

    upllc_feed_det u_cl_feed (
        .mclk(mclk),
        .resetn(resetn),
        .feed(cl_feed)
    );

    logic soft_sel;
    logic src_reg;
    logic [16:0] m_src;
    logic [9:0] n_src;
    logic [5:0] p_src;

    // Divider source: raw register codes or soft decoder presets
    always_comb begin
        soft_sel = cur_ff.usb_ctrl[upllc_pkg::BIT_SOFT_SEL];
        src_reg = cur_ff.usb_ctrl[upllc_pkg::BIT_SRC_SEL];
        if (src_reg) begin
            m_src = cur_ff.fb_code[upllc_pkg::FB_W-1:0];
            n_src = cur_ff.pre_post_code[upllc_pkg::PRE_W-1:0];
            p_src = cur_ff.pre_post_code[upllc_pkg::POST_LSB +:
                upllc_pkg::POST_W];
        end else if (soft_sel) begin
            m_src = upllc_pkg::SOFT_M1;
            n_src = upllc_pkg::SOFT_N1;
            p_src = upllc_pkg::SOFT_P1;
        end else begin
            m_src = upllc_pkg::SOFT_M0;
            n_src = upllc_pkg::SOFT_N0;
            p_src = upllc_pkg::SOFT_P0;
        end
    end

    always_comb begin
        nxt_cur = cur_ff;
        nxt_cur.rdata = 32'h0000_0000;
        // Register writes
        if (reg_wr) begin
            if (reg_addr == upllc_pkg::OFS_USB_CONTROL) begin
                nxt_cur.usb_ctrl = reg_wdata & upllc_pkg::MASK_USB_CONTROL;
            end else if (reg_addr == upllc_pkg::OFS_FB_CODE) begin
                nxt_cur.fb_code = {15'h0000,
                    reg_wdata[upllc_pkg::FB_W-1:0]};
            end else if (reg_addr == upllc_pkg::OFS_PRE_POST_CODE) begin
                nxt_cur.pre_post_code = reg_wdata
                    & upllc_pkg::MASK_LOW16;
            end else if (reg_addr == upllc_pkg::OFS_CL_FIRST) begin
                nxt_cur.cl_first = reg_wdata
                    & upllc_pkg::MASK_CL_CTRL;
            end else if (reg_addr == upllc_pkg::OFS_CL_SECOND) begin
                nxt_cur.cl_second = reg_wdata
                    & upllc_pkg::MASK_CL_CTRL;
            end else if (reg_addr == upllc_pkg::OFS_CL_GLOBAL) begin
                nxt_cur.cl_global = reg_wdata
                    & upllc_pkg::MASK_CL_GLOBAL;
            end else if (reg_addr == upllc_pkg::OFS_CLK_DETECT) begin
                nxt_cur.clk_detect = reg_wdata & upllc_pkg::MASK_LOW16;
            end else if (reg_addr == upllc_pkg::OFS_CLK_PRESENCE) begin
                nxt_cur.clk_presence = reg_wdata & upllc_pkg::MASK_LOW16;
            end
        end
        // USB feed accepted: load shadows whose request is set
        if (usb_feed.accept) begin
            if (cur_ff.usb_ctrl[upllc_pkg::BIT_FB_REQ]) begin
                nxt_cur.fb_act = m_src;
            end
            if (cur_ff.usb_ctrl[upllc_pkg::BIT_PRE_REQ]) begin
                nxt_cur.pre_act = n_src;
            end
            if (cur_ff.usb_ctrl[upllc_pkg::BIT_POST_REQ]) begin
                nxt_cur.post_act = p_src;
            end
        end
        // Contactless feed accepted: both control registers take effect
        if (cl_feed.accept) begin
            nxt_cur.cl_first_act = cur_ff.cl_first;
            nxt_cur.cl_second_act = cur_ff.cl_second;
        end
        // Read data, valid the cycle after the strobe; unmapped reads zero
        if (reg_rd) begin
            if (reg_addr == upllc_pkg::OFS_USB_CONTROL) begin
                nxt_cur.rdata = cur_ff.usb_ctrl;
            end else if (reg_addr == upllc_pkg::OFS_FB_CODE) begin
                nxt_cur.rdata = cur_ff.fb_code;
            end else if (reg_addr == upllc_pkg::OFS_PRE_POST_CODE) begin
                nxt_cur.rdata = cur_ff.pre_post_code;
            end else if (reg_addr == upllc_pkg::OFS_CL_FIRST) begin
                nxt_cur.rdata = cur_ff.cl_first;
            end else if (reg_addr == upllc_pkg::OFS_CL_SECOND) begin
                nxt_cur.rdata = cur_ff.cl_second;
            end else if (reg_addr == upllc_pkg::OFS_CL_GLOBAL) begin
                nxt_cur.rdata = cur_ff.cl_global;
            end else if (reg_addr == upllc_pkg::OFS_CLK_DETECT) begin
                nxt_cur.rdata = cur_ff.clk_detect;
            end else if (reg_addr == upllc_pkg::OFS_CLK_PRESENCE) begin
                nxt_cur.rdata = cur_ff.clk_presence;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cur_ff.usb_ctrl <= upllc_pkg::RST_USB_CONTROL;
            cur_ff.fb_code <= 32'h0000_0000;
            cur_ff.pre_post_code <= 32'h0000_0000;
            cur_ff.cl_first <= upllc_pkg::RST_CL_FIRST;
            cur_ff.cl_first_act <= upllc_pkg::RST_CL_FIRST;
            cur_ff.cl_second <= upllc_pkg::RST_CL_SECOND;
            cur_ff.cl_second_act <= upllc_pkg::RST_CL_SECOND;
            cur_ff.cl_global <= upllc_pkg::RST_CL_GLOBAL;
            cur_ff.clk_detect <= upllc_pkg::RST_CLK_DETECT;
            cur_ff.clk_presence <= upllc_pkg::RST_CLK_PRESENCE;
            cur_ff.fb_act <= 17'h00000;
            cur_ff.pre_act <= 10'h000;
            cur_ff.post_act <= 6'h00;
            cur_ff.rdata <= 32'h0000_0000;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    // Outputs straight from the register state
    assign reg_rdata = cur_ff.rdata;
    assign pll_power_down =
        cur_ff.usb_ctrl[upllc_pkg::BIT_POWER_DOWN];
    assign pll_out_clock_enable =
        cur_ff.usb_ctrl[upllc_pkg::BIT_CLK_EN];
    assign pll_bypass = cur_ff.usb_ctrl[upllc_pkg::BIT_PLL_BYPASS];
    assign pre_div_bypass =
        cur_ff.usb_ctrl[upllc_pkg::BIT_PRE_BYPASS];
    assign post_div_bypass =
        cur_ff.usb_ctrl[upllc_pkg::BIT_POST_BYPASS];
    assign skew_enable = cur_ff.usb_ctrl[upllc_pkg::BIT_SKEW];
    assign free_run_enable = cur_ff.usb_ctrl[upllc_pkg::BIT_FREE_RUN];
    assign fb_div_ratio = cur_ff.fb_act;
    assign pre_div_ratio = cur_ff.pre_act;
    assign post_div_ratio = cur_ff.post_act;
    assign cl_first_active = cur_ff.cl_first_act;
    assign cl_second_active = cur_ff.cl_second_act;
    assign cl_global_cfg = cur_ff.cl_global;

endmodule : upllc_top

/* tb/upllc_sva.sv */
/*
 * Checker for the USB PLL divider control block: port-level relations.
 * Assumes it is bound to upllc_top and sees only that module's ports.
 */
`timescale 1ns/100ps
module upllc_sva (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Controls and active settings
    input wire logic pll_power_down,
    input wire logic pll_out_clock_enable,
    input wire logic pll_bypass,
    input wire logic pre_div_bypass,
    input wire logic post_div_bypass,
    input wire logic skew_enable,
    input wire logic free_run_enable,
    input wire logic [16:0] fb_div_ratio,
    input wire logic [9:0] pre_div_ratio,
    input wire logic [5:0] post_div_ratio,
    input wire logic [31:0] cl_first_active,
    input wire logic [31:0] cl_global_cfg
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic ctl_wr;
    logic [6:0] ctl_vec;
    assign ctl_wr = reg_wr && reg_addr == upllc_pkg::OFS_USB_CONTROL;
    assign ctl_vec = {free_run_enable, skew_enable, post_div_bypass,
        pre_div_bypass, pll_bypass, pll_out_clock_enable, pll_power_down};

    rd_idle_zero_a: assert property (
        !$past(reg_rd) |-> reg_rdata == '0)
        else $error("read data not zero outside read slot");
    power_down_wr_a: assert property (
        ctl_wr |=> pll_power_down == $past(reg_wdata[0]))
        else $error("power down does not follow write");
    clk_enable_wr_a: assert property (
        ctl_wr |=> pll_out_clock_enable == $past(reg_wdata[1]))
        else $error("output clock enable does not follow write");
    pll_bypass_wr_a: assert property (
        ctl_wr |=> pll_bypass == $past(reg_wdata[2]))
        else $error("pll bypass does not follow write");
    div_bypass_wr_a: assert property (
        ctl_wr |=>
        {post_div_bypass, pre_div_bypass} == $past(reg_wdata[4:3]))
        else $error("divider bypass does not follow write");
    mode_bits_wr_a: assert property (
        ctl_wr |=> {free_run_enable, skew_enable} == $past(reg_wdata[6:5]))
        else $error("mode bits do not follow write");
    ctrl_hold_a: assert property (
        !ctl_wr |=> $stable(ctl_vec))
        else $error("control outputs moved without a write");
    ctrl_readback_a: assert property (
        reg_rd && reg_addr == upllc_pkg::OFS_USB_CONTROL |=>
        reg_rdata[6:0] == ctl_vec && !reg_rdata[31])
        else $error("control read back differs from outputs");
    usb_feed_a: assert property (
        $changed({fb_div_ratio, pre_div_ratio, post_div_ratio}) |->
        $past(reg_wr, 2) && $past(reg_addr, 2) == upllc_pkg::OFS_USB_FEED
        && $past(reg_wdata[7:0], 2) == upllc_pkg::FEED_KEY2)
        else $error("dividers changed without a usb feed");
    cl_feed_a: assert property (
        $changed(cl_first_active) |->
        $past(reg_wr, 2) && $past(reg_addr, 2) == upllc_pkg::OFS_CL_FEED
        && $past(reg_wdata[7:0], 2) == upllc_pkg::FEED_KEY2)
        else $error("contactless control changed without a feed");
    cl_global_wr_a: assert property (
        reg_wr && reg_addr == upllc_pkg::OFS_CL_GLOBAL |=>
        cl_global_cfg == ($past(reg_wdata) & upllc_pkg::MASK_CL_GLOBAL))
        else $error("global control write not masked");

    cover property (ctl_wr);
    cover property ($changed(fb_div_ratio));
    cover property ($changed(cl_first_active));
endmodule : upllc_sva

bind upllc_top upllc_sva i_upllc_sva (.mclk(mclk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pll_power_down(pll_power_down),
    .pll_out_clock_enable(pll_out_clock_enable), .pll_bypass(pll_bypass),
    .pre_div_bypass(pre_div_bypass), .post_div_bypass(post_div_bypass),
    .skew_enable(skew_enable), .free_run_enable(free_run_enable),
    .fb_div_ratio(fb_div_ratio), .pre_div_ratio(pre_div_ratio),
    .post_div_ratio(post_div_ratio), .cl_first_active(cl_first_active),
    .cl_global_cfg(cl_global_cfg));

/* tb/upllc_tb.sv */
/*
 * Testbench for upllc_top: register access, control bits, feed sequences.
 * Assumes the checker is bound from its own file.
 */
`timescale 1ns/100ps
module upllc_tb;
    logic mclk, resetn, reg_wr, reg_rd;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, cl_first_active, cl_global_cfg;
    logic [31:0] cl_second_active;
    logic pll_power_down, pll_out_clock_enable, pll_bypass, pre_div_bypass;
    logic post_div_bypass, skew_enable, free_run_enable;
    logic [16:0] fb_div_ratio;
    logic [9:0] pre_div_ratio;
    logic [5:0] post_div_ratio;
    logic [6:0] ctl_vec;
    int n_mismatch, compares;
    logic [7:0] rst_addr [9] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20,
        8'h24, 8'h2c, 8'h28};
    logic [31:0] rst_val [9] = '{32'h00f9_0001, 32'h0, 32'h0, 32'h02e3_b190,
        32'h02e1_21e0, 32'h0000_00c0, 32'h0000_11ad, 32'h0000_000f, 32'h0};

    assign ctl_vec = {free_run_enable, skew_enable, post_div_bypass,
        pre_div_bypass, pll_bypass, pll_out_clock_enable, pll_power_down};

    upllc_top i_upllc_top (.mclk(mclk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .pll_power_down(pll_power_down),
        .pll_out_clock_enable(pll_out_clock_enable), .pll_bypass(pll_bypass),
        .pre_div_bypass(pre_div_bypass), .post_div_bypass(post_div_bypass),
        .skew_enable(skew_enable), .free_run_enable(free_run_enable),
        .fb_div_ratio(fb_div_ratio), .pre_div_ratio(pre_div_ratio),
        .post_div_ratio(post_div_ratio), .cl_first_active(cl_first_active),
        .cl_second_active(cl_second_active),
        .cl_global_cfg(cl_global_cfg));

    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp_reg

    task automatic cmp_ctl(input logic [6:0] exp);
        cmp_reg({25'h0, ctl_vec}, {25'h0, exp});
    endtask : cmp_ctl

    task automatic cmp_div(input logic [16:0] m, input logic [9:0] n,
        input logic [5:0] p);
        cmp_reg({15'h0, fb_div_ratio}, {15'h0, m});
        cmp_reg({22'h0, pre_div_ratio}, {22'h0, n});
        cmp_reg({26'h0, post_div_ratio}, {26'h0, p});
    endtask : cmp_div

    // Strobe is left high so writes can follow each other with no gap
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= d;
    endtask : wr

    task automatic idle();
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(negedge mclk);
    endtask : idle

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        cmp_reg(reg_rdata, exp);
    endtask : rd

    // Ends between the accept edge and the edge that loads the shadows
    task automatic feed(input logic [7:0] a);
        wr(a, 32'h0000_00aa);
        wr(a, 32'h0000_0055);
        idle();
    endtask : feed

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    initial begin
        #200us;
        n_mismatch++;
        wrap_up();
    end

    initial begin
        resetn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        n_mismatch = 0;
        compares = 0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        foreach (rst_addr[i]) begin
            rd(rst_addr[i], rst_val[i]);
        end
        cmp_ctl(7'h01);
        cmp_div(17'h0, 10'h0, 6'h0);
        for (int i = 0; i < 7; i++) begin
            wr(8'h0c, 32'h1 << i);
            idle();
            cmp_ctl(7'h1 << i);
            rd(8'h0c, 32'h1 << i);
        end
        wr(8'h0c, 32'hffff_ffff);
        wr(8'h28, 32'h1234_5678);
        idle();
        cmp_ctl(7'h7f);
        rd(8'h0c, 32'h7fff_ffff);
        rd(8'h28, 32'h0);
        // Raw codes with reserved bits set, fb request only
        wr(8'h10, 32'hfff1_abcd);
        wr(8'h14, 32'hffff_abc5);
        wr(8'h0c, 32'h0100_0080);
        rd(8'h10, 32'h0001_abcd);
        rd(8'h14, 32'h0000_abc5);
        wr(8'h30, 32'h0000_00aa);
        wr(8'h0c, 32'h0100_0080);
        wr(8'h30, 32'h0000_0055);
        idle();
        @(negedge mclk);
        cmp_div(17'h0, 10'h0, 6'h0);
        feed(8'h30);
        cmp_div(17'h0, 10'h0, 6'h0);
        @(negedge mclk);
        cmp_div(17'h1abcd, 10'h0, 6'h0);
        wr(8'h0c, 32'h0100_0380);
        feed(8'h30);
        @(negedge mclk);
        cmp_div(17'h1abcd, 10'h3c5, 6'h2a);
        for (int s = 0; s < 2; s++) begin
            wr(8'h0c, (s == 0) ? 32'h0000_0380 : 32'h4000_0380);
            feed(8'h30);
            @(negedge mclk);
            if (s == 0)
                cmp_div(17'h00258, 10'h071, 6'h03);
            else
                cmp_div(17'h0005c, 10'h00d, 6'h04);
        end
        wr(8'h18, 32'hffff_ffff);
        wr(8'h1c, 32'hf123_4567);
        idle();
        cmp_reg(cl_first_active, 32'h02e3_b190);
        cmp_reg(cl_second_active, 32'h02e1_21e0);
        rd(8'h18, 32'h0fff_ffff);
        rd(8'h1c, 32'h0123_4567);
        feed(8'h34);
        @(negedge mclk);
        cmp_reg(cl_first_active, 32'h0fff_ffff);
        cmp_reg(cl_second_active, 32'h0123_4567);
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, 32'h0000_7fff);
        cmp_reg(cl_global_cfg, 32'h0000_7fff);
        wr(8'h24, 32'hffff_ffff);
        rd(8'h24, 32'h0000_ffff);
        @(posedge mclk);
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        @(negedge mclk);
        cmp_ctl(7'h01);
        cmp_div(17'h0, 10'h0, 6'h0);
        cmp_reg(cl_first_active, 32'h02e3_b190);
        wrap_up();
    end
endmodule : upllc_tb
